/* File: rtl/lbio_pkg.sv */
// Package with shared constants and types of the local bus I/O controller
package lbio_pkg;
   // Processor cycle status carried together
   typedef struct packed {
      logic writeNotRead;
      logic memNotIo;
      logic dataNotCode;
   } lbio_status_t;

   // Command strobes, active low
   typedef struct packed {
      logic memoryReadCmdN;
      logic ioReadCmdN;
      logic ioWriteCmdN;
      logic interruptAckCmdN;
   } lbio_cmd_t;

   localparam int ADDR_W = 32;
   localparam int CS_W = 4;
   localparam int WS_W = 4;
   // Memory decoder output that enables the I/O decoder
   localparam int MEM_IO_SEL = 3;
   // Address bit positions of the decoders
   localparam int MEM_DEC_LO = 30;
   localparam int IO_DEC_LO = 4;
   localparam int COMP_DEC_LO = 6;
   localparam logic [9:0] COMP_BASE = 10'h001;
   // Default wait states per I/O select, for memory and for acknowledge
   localparam logic [15:0] WAIT_IO_DEF = 16'h5441;
   localparam logic [3:0] WAIT_MEM_DEF = 4'h2;
   localparam logic [3:0] WAIT_INTERRUPT_ACK_CMD_N_DEF = 4'h1;
   localparam lbio_cmd_t CMD_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1};
endpackage

/* File: rtl/local_bus_io_controller.sv */
// Local bus I/O controller: latch, decode, commands, wait states, ready
`timescale 1ns/1ns
`default_nettype none
module local_bus_io_controller #(
   parameter logic [15:0] WAIT_IO = lbio_pkg::WAIT_IO_DEF,
   parameter logic [3:0] WAIT_MEM = lbio_pkg::WAIT_MEM_DEF,
   parameter logic [3:0] WAIT_INTERRUPT_ACK_CMD_N = lbio_pkg::WAIT_INTERRUPT_ACK_CMD_N_DEF
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic addrStrobeN,
   input wire logic [lbio_pkg::ADDR_W-1:0] cpuAddr,
   input wire lbio_pkg::lbio_status_t cpuStatus,
   output logic latch_gate_input,
   output logic latchOutEnableN,
   output logic [lbio_pkg::ADDR_W-1:0] latchedAddr,
   output logic [lbio_pkg::CS_W-1:0] memChipSelN,
   output logic [lbio_pkg::CS_W-1:0] ioChipSelN,
   output logic buffer_direction,
   output logic buffer_enable_n,
   output lbio_pkg::lbio_cmd_t cmdN,
   output logic wait_count_done_n,
   output logic readyN
);
   // Decoders read fixed address bits and give one-of-four outputs
   if (lbio_pkg::CS_W != 4 || lbio_pkg::WS_W != 4 ||
       lbio_pkg::ADDR_W < lbio_pkg::MEM_DEC_LO + 2) begin
      $error("Address, select or wait width not served");
   end

   typedef enum {LB_IDLE, LB_START, LB_WAIT, LB_DONE} lbio_state_t;

   // Input synchronisers
   logic asSync1Ff, asSync2Ff;
   logic [lbio_pkg::ADDR_W-1:0] addrSync1Ff, addrSync2Ff;
   lbio_pkg::lbio_status_t stSync1Ff, stSync2Ff;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         asSync1Ff <= 1'b1;
         asSync2Ff <= 1'b1;
         addrSync1Ff <= '0;
         addrSync2Ff <= '0;
         stSync1Ff <= '0;
         stSync2Ff <= '0;
      end else begin
         asSync1Ff <= addrStrobeN;
         asSync2Ff <= asSync1Ff;
         addrSync1Ff <= cpuAddr;
         addrSync2Ff <= addrSync1Ff;
         stSync1Ff <= cpuStatus;
         stSync2Ff <= stSync1Ff;
      end
   end

   logic strobeN;
   assign strobeN = asSync2Ff;

   // Combinational decoders, no storage
   logic [3:0] memDecN, ioDecN;
   logic compHit;
   always_comb begin
      memDecN = 4'hF;
      ioDecN = 4'hF;
      if (!stSync2Ff.memNotIo) begin
         memDecN[lbio_pkg::MEM_IO_SEL] = 1'b0;
      end else begin
         memDecN[addrSync2Ff[lbio_pkg::MEM_DEC_LO +: 2]] = 1'b0;
      end
      if (!memDecN[lbio_pkg::MEM_IO_SEL] && !stSync2Ff.memNotIo) begin
         ioDecN[addrSync2Ff[lbio_pkg::IO_DEC_LO +: 2]] = 1'b0;
      end
      compHit = !stSync2Ff.memNotIo &&
         (addrSync2Ff[lbio_pkg::COMP_DEC_LO +: 10] == lbio_pkg::COMP_BASE);
   end

   // Wait count from I/O selects, memory flag or acknowledge; acknowledge first
   function automatic logic [3:0] waitOf(input logic [3:0] ioN,
                                         input logic mem,
                                         input logic interrupt_ack_cmd_n);
      logic [3:0] w;
      w = WAIT_MEM;
      if (interrupt_ack_cmd_n) begin
         w = WAIT_INTERRUPT_ACK_CMD_N;
      end else if (!mem) begin
         for (int i = 0; i < 4; i++) begin
            if (!ioN[i]) begin
               w = WAIT_IO[i*4 +: 4];
            end
         end
      end
      return w;
   endfunction

   lbio_state_t stateFf, nxt_stateFf;
   logic latchFf, nxt_latchFf;
   logic [lbio_pkg::ADDR_W-1:0] addrFf, nxt_addrFf;
   logic [3:0] memCsFf, nxt_memCsFf, ioCsFf, nxt_ioCsFf;
   logic dirFf, nxt_dirFf, denFf, nxt_denFf;
   lbio_pkg::lbio_cmd_t cmdFf, nxt_cmdFf;
   logic [lbio_pkg::WS_W-1:0] cntFf, nxt_cntFf;
   logic doneFf, nxt_doneFf, rdyFf, nxt_rdyFf, compFf, nxt_compFf;
   logic prevStrobeNFf;
   lbio_pkg::lbio_status_t stFf, nxt_stFf;

   always_comb begin
      nxt_stateFf = stateFf;
      nxt_latchFf = 1'b0;
      nxt_addrFf = addrFf;
      nxt_memCsFf = memCsFf;
      nxt_ioCsFf = ioCsFf;
      nxt_dirFf = dirFf;
      nxt_denFf = denFf;
      nxt_cmdFf = cmdFf;
      nxt_cntFf = cntFf;
      nxt_doneFf = 1'b1;
      nxt_rdyFf = 1'b1;
      nxt_compFf = compFf;
      nxt_stFf = stFf;
      unique case (stateFf)
         LB_IDLE: begin
            if (prevStrobeNFf && !strobeN) begin
               nxt_latchFf = 1'b1;
               nxt_addrFf = addrSync2Ff;
               nxt_memCsFf = memDecN;
               nxt_ioCsFf = ioDecN;
               nxt_dirFf = stSync2Ff.writeNotRead;
               nxt_compFf = compHit;
               nxt_stFf = stSync2Ff;
               nxt_stateFf = LB_START;
            end
         end
         LB_START: begin
            nxt_cmdFf = lbio_pkg::CMD_IDLE;
            unique case ({stFf.memNotIo, stFf.dataNotCode, stFf.writeNotRead})
               3'h2: nxt_cmdFf.ioReadCmdN = 1'b0;
               3'h3: nxt_cmdFf.ioWriteCmdN = 1'b0;
               3'h0: nxt_cmdFf.interruptAckCmdN = 1'b0;
               3'h4, 3'h6: nxt_cmdFf.memoryReadCmdN = 1'b0;
               default: nxt_cmdFf = lbio_pkg::CMD_IDLE;
            endcase
            // Companion drives its own read data
            nxt_denFf = compFf && !stFf.writeNotRead;
            nxt_cntFf = waitOf(ioCsFf, stFf.memNotIo,
               !stFf.memNotIo && !stFf.dataNotCode);
            nxt_stateFf = LB_WAIT;
         end
         LB_WAIT: begin
            if (cntFf == '0) begin
               nxt_doneFf = 1'b0;
               nxt_rdyFf = 1'b0;
               nxt_stateFf = LB_DONE;
            end else begin
               nxt_cntFf = cntFf - 4'h1;
            end
         end
         LB_DONE: begin
            nxt_cmdFf = lbio_pkg::CMD_IDLE;
            nxt_denFf = 1'b1;
            nxt_stateFf = LB_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         stateFf <= LB_IDLE;
         latchFf <= 1'b0;
         addrFf <= '0;
         memCsFf <= 4'hF;
         ioCsFf <= 4'hF;
         dirFf <= 1'b0;
         denFf <= 1'b1;
         cmdFf <= lbio_pkg::CMD_IDLE;
         cntFf <= '0;
         doneFf <= 1'b1;
         rdyFf <= 1'b1;
         compFf <= 1'b0;
         stFf <= '0;
         prevStrobeNFf <= 1'b1;
      end else begin
         stateFf <= nxt_stateFf;
         latchFf <= nxt_latchFf;
         addrFf <= nxt_addrFf;
         memCsFf <= nxt_memCsFf;
         ioCsFf <= nxt_ioCsFf;
         dirFf <= nxt_dirFf;
         denFf <= nxt_denFf;
         cmdFf <= nxt_cmdFf;
         cntFf <= nxt_cntFf;
         doneFf <= nxt_doneFf;
         rdyFf <= nxt_rdyFf;
         compFf <= nxt_compFf;
         stFf <= nxt_stFf;
         prevStrobeNFf <= strobeN;
      end
   end

   logic oeFf;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         oeFf <= 1'b0;
      end else begin
         oeFf <= 1'b0;
      end
   end

   assign latch_gate_input = latchFf;
   assign latchOutEnableN = oeFf;
   assign latchedAddr = addrFf;
   assign memChipSelN = memCsFf;
   assign ioChipSelN = ioCsFf;
   assign buffer_direction = dirFf;
   assign buffer_enable_n = denFf;
   assign cmdN = cmdFf;
   assign wait_count_done_n = doneFf;
   assign readyN = rdyFf;

   // Steps of one bus cycle
   sequence lbio_seq_start;
      stateFf == LB_START;
   endsequence
   sequence lbio_seq_ready;
      !readyN && !wait_count_done_n;
   endsequence

   a_latch_on_start: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      $rose(latchFf) |-> stateFf == LB_START)
      else $error("Latch strobe without cycle start");
   a_addr_latched: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      $rose(latchFf) |-> latchedAddr == $past(addrSync2Ff) &&
      memChipSelN == $past(memDecN) && ioChipSelN == $past(ioDecN))
      else $error("Address or selects not latched");
   a_oe_always_on: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      !latchOutEnableN)
      else $error("Latch output enable dropped");
   a_dir_latched: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      latchFf |-> buffer_direction == $past(stSync2Ff.writeNotRead))
      else $error("Direction not latched status");
   a_one_cmd: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      $countones(~cmdN) <= 1)
      else $error("More than one command active");
   a_io_read_cmd: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      stateFf == LB_START && stFf == 3'b001 |=> !cmdN.ioReadCmdN)
      else $error("I/O read command missing");
   a_io_write_cmd: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      stateFf == LB_START && stFf == 3'b101 |=> !cmdN.ioWriteCmdN)
      else $error("I/O write command missing");
   a_mem_read_cmd: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      stateFf == LB_START && stFf.memNotIo && !stFf.writeNotRead
      |=> !cmdN.memoryReadCmdN)
      else $error("Memory read command missing");
   a_interrupt_ack_cmd_n_cmd: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      stateFf == LB_START && stFf == 3'b000 |=> !cmdN.interruptAckCmdN)
      else $error("Acknowledge command missing");
   a_buffer_on: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      stateFf == LB_START && !compFf |=> !buffer_enable_n)
      else $error("Buffer not enabled for cycle");
   a_ready_bound: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      lbio_seq_start |-> ##[2:17] lbio_seq_ready)
      else $error("Ready not returned in time");
   a_no_early_ready: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      stateFf == LB_WAIT && cntFf != '0 |=> readyN)
      else $error("Ready before wait states elapsed");
   a_release_cmd: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      lbio_seq_ready |=> cmdN == lbio_pkg::CMD_IDLE && buffer_enable_n)
      else $error("Command held after ready");
   a_comp_isolate: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      stateFf == LB_START && compFf && !stFf.writeNotRead
      |=> buffer_enable_n)
      else $error("Buffer on during companion read");
endmodule
`default_nettype wire

/* File: tb/lbio_cpu_model.sv */
// Processor bus master model issuing one cycle per go request
`timescale 1ns/1ns
`default_nettype none
module lbio_cpu_model (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic go,
   input wire logic [31:0] reqAddr,
   input wire lbio_pkg::lbio_status_t reqStatus,
   input wire logic readyN,
   output logic addrStrobeN,
   output logic [31:0] cpuAddr,
   output lbio_pkg::lbio_status_t cpuStatus
);
   logic seen;
   // Ready taken at the rising edge, release on the next falling edge
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) seen <= 1'b0;
      else seen <= !addrStrobeN && !readyN;
   end
   // Released bus shows inverted values, never the last ones
   always_ff @(negedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         addrStrobeN <= 1'b1;
         cpuAddr <= '0;
         cpuStatus <= '0;
      end else if (go && addrStrobeN) begin
         addrStrobeN <= 1'b0;
         cpuAddr <= reqAddr;
         cpuStatus <= reqStatus;
      end else if (seen) begin
         addrStrobeN <= 1'b1;
         cpuAddr <= ~cpuAddr;
         cpuStatus <= ~cpuStatus;
      end
   end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench of the local bus I/O controller
`timescale 1ns/1ns
`default_nettype none
module tb;
   typedef struct {logic [31:0] a; lbio_pkg::lbio_status_t s;
      lbio_pkg::lbio_cmd_t c; int ws; logic den, cs;} lbio_exp_t;
   logic core_clk = 0, rst_b = 0, go = 0, addrStrobeN, readyN;
   logic [31:0] reqAddr = 0, cpuAddr, latchedAddr, rnd = 80, r;
   lbio_pkg::lbio_status_t reqStatus = '0, cpuStatus;
   logic latch_gate_input, latchOutEnableN, buffer_direction;
   logic buffer_enable_n, wait_count_done_n;
   logic [3:0] memChipSelN, ioChipSelN;
   lbio_pkg::lbio_cmd_t cmdN;
   lbio_exp_t q[$];
   lbio_exp_t e;
   int n_errors = 0, cmp_count = 0, cnt = 0, nLat = 0;
   logic denSeen = 0, chkIdle = 0;
   always #20 core_clk = ~core_clk;
   local_bus_io_controller DUT (.core_clk, .rst_b, .addrStrobeN,
      .cpuAddr, .cpuStatus, .latch_gate_input, .latchOutEnableN,
      .latchedAddr, .memChipSelN, .ioChipSelN, .buffer_direction,
      .buffer_enable_n, .cmdN, .wait_count_done_n, .readyN);
   lbio_cpu_model cpu (.core_clk, .rst_b, .go, .reqAddr, .reqStatus,
      .readyN, .addrStrobeN, .cpuAddr, .cpuStatus);
   function automatic logic [31:0] xs();
      rnd ^= rnd << 13;
      rnd ^= rnd >> 17;
      rnd ^= rnd << 5;
      return rnd;
   endfunction
   task automatic chk(string n, logic [31:0] x, logic [31:0] g);
      cmp_count++;
      if (g !== x) begin
         n_errors++;
         $display("MISMATCH %s exp %h got %h", n, x, g);
      end
   endtask
   task automatic finish_test();
      $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Bits of s are write, memory, data
   task automatic run(logic [31:0] a, logic [2:0] s);
      lbio_exp_t x;
      int k;
      x.a = a;
      x.s = s;
      x.c = lbio_pkg::CMD_IDLE;
      x.cs = s[0];
      x.den = !(!s[2] && !s[1] && a[15:6] == 10'h001);
      if (s[1]) begin
         x.c.memoryReadCmdN = 1'b0;
         x.ws = lbio_pkg::WAIT_MEM_DEF;
      end else if (!s[0]) begin
         x.c.interruptAckCmdN = 1'b0;
         x.ws = lbio_pkg::WAIT_INTERRUPT_ACK_CMD_N_DEF;
      end else begin
         if (s[2]) x.c.ioWriteCmdN = 1'b0;
         else x.c.ioReadCmdN = 1'b0;
         x.ws = lbio_pkg::WAIT_IO_DEF[4 * a[5:4] +: 4];
      end
      q.push_back(x);
      reqAddr <= a;
      reqStatus <= s;
      go <= 1'b1;
      @(negedge core_clk);
      go <= 1'b0;
      @(negedge core_clk);
      for (k = 0; k < 200 && addrStrobeN !== 1'b1; k++) @(negedge core_clk);
      if (k == 200) chk("release", 1, 0);
      repeat (4) @(negedge core_clk);
   endtask
   always @(negedge core_clk) begin
      if (rst_b) begin
         if (latch_gate_input === 1'b1) nLat++;
         if (readyN === 1'b0) begin
            e = q.pop_front();
            chk("addr", e.a, latchedAddr);
            chk("dir", e.s.writeNotRead, buffer_direction);
            chk("cmd", e.c, cmdN);
            chk("waits", e.ws + 1, cnt);
            chk("done", 0, wait_count_done_n);
            chk("denOn", e.den, denSeen);
            chk("latch", 1, nLat);
            chk("oe", 0, latchOutEnableN);
            if (e.cs) begin
               chk("memcs", e.s.memNotIo ? 4'(~(4'h1 << e.a[31:30])) :
                  4'h7, memChipSelN);
               chk("iocs", e.s.memNotIo ? 4'hF :
                  4'(~(4'h1 << e.a[5:4])), ioChipSelN);
            end
            cnt = 0;
            nLat = 0;
            denSeen = 0;
            chkIdle = 1;
         end else begin
            if (chkIdle) chk("idle", {lbio_pkg::CMD_IDLE, 1'b1},
               {cmdN, buffer_enable_n});
            chkIdle = 0;
            if (cmdN !== lbio_pkg::CMD_IDLE) cnt++;
            if (cmdN !== lbio_pkg::CMD_IDLE && buffer_enable_n === 1'b0)
               denSeen = 1;
         end
      end
   end
   initial begin
      #(40 * 3000);
      n_errors++;
      finish_test();
   end
   initial begin
      repeat (5) @(negedge core_clk);
      rst_b = 1;
      @(negedge core_clk);
      for (int i = 0; i < 8; i++)
         run(xs() & 32'hFFFF_FFCF | 32'h400 | 32'(i % 4) << 4,
            {i[2], 2'b01});
      $display("Test io cycles done");
      for (int i = 0; i < 8; i++) begin
         r = xs();
         run({i[1:0], r[29:0]}, {2'b01, i[2]});
      end
      $display("Test memory reads done");
      run(xs(), 3'h0);
      run(32'h0000_0070, 3'h1);
      run(32'h0000_0050, 3'h5);
      $display("Test acknowledge and companion done");
      chk("left", 0, q.size());
      finish_test();
   end
endmodule
`default_nettype wire
